//--- hdl/dfd_map.svh
// Constants for the disk FIFO DMA bus-master sequencer.
// Included by every design file of the block except the package; definitions only.
// Operation
// - Address-phase indicator low exactly while the bus carries an address.
// - Read/write and prefetch strobes generated whatever the transfer direction.
// - Status lines show a memory cycle in Ts, T1 and T2, otherwise high.
// - Data buffer enable driven during transfers; direction follows transfer direction.
// - Transfer-active asserted while the sequencer owns the bus.
// - Ready is synchronized; low ready in T3 inserts Tw; early lows ignored.
// - Wait states continue without limit while ready stays low.
// - Start command gives a low strobe pulse that sets the running flag.
// - FIFO available raises request; grant raises active; next cycle is Ts.
// - On grant loss finish word, drop request, clear active a cycle later.
// - Wait one more cycle, then request again if FIFO available.
// - Running flag stays high while suspended with operation incomplete.
// - Renewed grant reasserts active and resumes at the next cycle.
// - FIFO unusable releases the bus; no request until usable.
// - FIFO usable again raises the request as in a normal start.
// - Terminal count goes low when words done equal programmed count.
// - Completion asserts the low interrupt and clears the running flag.
// - FIFO unavailable when full to disk or empty to memory.
// - Illegal inputs set error, freeze status, interrupt, return to idle.
// - Each word increments two's-complement count and 24-bit address.
`ifndef DFD_MAP_SVH
`define DFD_MAP_SVH
`define DFD_ADDR_W 24
`define DFD_COUNT_W 8
`define DFD_COUNT_ZERO 8'h00
`define DFD_ADDR_ZERO 24'h000000
`define DFD_ADDR_STEP 24'h000002
`define DFD_COUNT_STEP 8'h01
// Bus status codes on the three status lines
`define DFD_STAT_PASSIVE 3'h7
`define DFD_STAT_MEM_READ 3'h5
`define DFD_STAT_MEM_WRITE 3'h6
`define DFD_SYNC_ZERO 2'h0
`endif

//--- hdl/dfd_pkg.sv
// Types shared by the sequencer and its helpers.
// Assumes dfd_map.svh is compiled alongside.
package dfd_pkg;
  typedef enum logic [3:0] {
    DFD_IDLE = 4'b0000,
    DFD_WAIT_FIFO = 4'b0001,
    DFD_SEND_REQ = 4'b0010,
    DFD_WAIT_GRANT = 4'b0011,
    DFD_TS = 4'b0100,
    DFD_T1 = 4'b0101,
    DFD_T2 = 4'b0110,
    DFD_T3 = 4'b0111,
    DFD_TW = 4'b1000,
    DFD_T4 = 4'b1001,
    DFD_DROP = 4'b1010,
    DFD_RELEASE = 4'b1011,
    DFD_DONE = 4'b1100
  } dfd_state_t;

  // Bus-side control group, all registered
  typedef struct packed {
    logic addr_phase_n;
    logic mem_read_write_n;
    logic queue_prefetch_n;
    logic status_line_gate;
    logic [2:0] status_lines;
    logic data_buffer_enable_n;
    logic data_buffer_dir;
  } dfd_bus_ctl_t;
endpackage

//--- hdl/dfd_sync2.sv
// Two-flop synchronizer for the ready and grant levels.
// Inputs may change at any time relative to ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "dfd_map.svh"
module dfd_sync2
  import dfd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  logic [1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1 <= `DFD_SYNC_ZERO;
      sync_out <= `DFD_SYNC_ZERO;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // dfd_sync2
`default_nettype wire

//--- hdl/dfd_word_counter.sv
// Word count and address counters for one operation.
// Host loads them while the sequencer is idle.
`timescale 1ns/1ns
`default_nettype none
`include "dfd_map.svh"
module dfd_word_counter
  import dfd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Loading
  input wire logic load_count,
  input wire logic [`DFD_COUNT_W-1:0] count_value,
  input wire logic load_addr,
  input wire logic [`DFD_ADDR_W-1:0] addr_value,
  // Stepping and results
  input wire logic word_step,
  output logic [`DFD_ADDR_W-1:0] bus_address,
  output logic terminal_count_n
);
  logic [`DFD_COUNT_W-1:0] count;

  // Count value after one more word; wraps through zero
  function automatic logic [`DFD_COUNT_W-1:0] step_count(input logic [`DFD_COUNT_W-1:0] c);
    step_count = c + `DFD_COUNT_STEP;
  endfunction

  // Two's-complement count climbs toward zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count <= `DFD_COUNT_ZERO;
    end else if (load_count) begin
      count <= count_value;
    end else if (word_step) begin
      count <= step_count(count);
    end
  end

  // Address advances one word per transfer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_address <= `DFD_ADDR_ZERO;
    end else if (load_addr) begin
      bus_address <= addr_value;
    end else if (word_step) begin
      bus_address <= bus_address + `DFD_ADDR_STEP;
    end
  end

  // Low once every programmed word has moved
  always_ff @(posedge ref_clk) begin
    if (sys_rst || load_count) begin
      terminal_count_n <= 1'b1;
    end else if (word_step) begin
      // Follows the stepped count so T4 of the last word already sees it
      terminal_count_n <= (step_count(count) != `DFD_COUNT_ZERO);
    end
  end
endmodule // dfd_word_counter
`default_nettype wire

//--- hdl/dfd_sequencer.sv
// Bus-master sequencer moving words between the disk FIFO and memory.
// Assumes synchronous command inputs; ready and grant are asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "dfd_map.svh"
module dfd_sequencer
  import dfd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Host commands
  input wire logic begin_transfer_cmd,
  input wire logic mem_to_disk,
  input wire logic load_count,
  input wire logic [`DFD_COUNT_W-1:0] count_value,
  input wire logic load_addr,
  input wire logic [`DFD_ADDR_W-1:0] addr_value,
  input wire logic status_clear,
  // FIFO state
  input wire logic queue_full,
  input wire logic queue_empty,
  // Memory and arbiter
  input wire logic memory_ready_in,
  input wire logic disk_bus_grant,
  output logic disk_bus_request,
  // Bus controls
  output dfd_bus_ctl_t bus_ctl,
  output logic [`DFD_ADDR_W-1:0] bus_address,
  // Status to host and controller
  output logic begin_strobe_n,
  output logic sequencer_running,
  output logic transfer_active,
  output logic terminal_count_n,
  output logic disk_xfer_irq_n,
  output logic error_flag
);
  dfd_state_t state;
  dfd_state_t next_state;
  logic [1:0] synced;
  logic synced_ready;
  logic synced_bus_grant;
  logic trimmed_ready;
  logic queue_usable;
  logic illegal_input;
  logic word_step;
  dfd_bus_ctl_t next_bus_ctl;

  // Status line code for the direction of the memory cycle
  function automatic logic [2:0] mem_status(input logic to_disk);
    mem_status = to_disk ? `DFD_STAT_MEM_READ : `DFD_STAT_MEM_WRITE;
  endfunction

  // Bus-cycle states, where the sequencer drives the bus
  function automatic logic in_bus_cycle(input dfd_state_t s);
    in_bus_cycle = (s == DFD_T1) || (s == DFD_T2) || (s == DFD_T3) || (s == DFD_TW) || (s == DFD_T4);
  endfunction

  dfd_sync2 u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({memory_ready_in, disk_bus_grant}),
    .sync_out(synced)
  );

  assign synced_ready = synced[1];
  assign synced_bus_grant = synced[0];

  // Ready only matters in T3 and Tw; earlier dips are ignored
  assign trimmed_ready = synced_ready || !((state == DFD_T3) || (state == DFD_TW));

  // FIFO unavailable: full toward disk, empty toward memory
  assign queue_usable = !((queue_full && mem_to_disk) || (queue_empty && !mem_to_disk));

  // A FIFO both full and empty cannot happen
  assign illegal_input = queue_full && queue_empty;

  // One word completes when the data phase ends
  assign word_step = (state == DFD_T3 || state == DFD_TW) && trimmed_ready;

  dfd_word_counter u_count (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .load_count(load_count),
    .count_value(count_value),
    .load_addr(load_addr),
    .addr_value(addr_value),
    .word_step(word_step),
    .bus_address(bus_address),
    .terminal_count_n(terminal_count_n)
  );

  // Start strobe, one cycle low per command
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      begin_strobe_n <= 1'b1;
    end else begin
      begin_strobe_n <= !(begin_transfer_cmd && state == DFD_IDLE);
    end
  end

  // Next-state logic
  always_comb begin
    next_state = state;
    if (illegal_input) begin
      next_state = DFD_IDLE;
    end else begin
      case (state)
        DFD_IDLE: begin
          // Only a fresh start leaves idle, never completion alone
          if (!begin_strobe_n) begin
            next_state = DFD_WAIT_FIFO;
          end
        end
        DFD_WAIT_FIFO: begin
          if (queue_usable) begin
            next_state = DFD_SEND_REQ;
          end
        end
        DFD_SEND_REQ: begin
          next_state = DFD_WAIT_GRANT;
        end
        DFD_WAIT_GRANT: begin
          // Grant returns only after the other master is gone
          if (synced_bus_grant) begin
            next_state = DFD_TS;
          end
        end
        DFD_TS: begin
          next_state = DFD_T1;
        end
        DFD_T1: begin
          next_state = DFD_T2;
        end
        DFD_T2: begin
          next_state = DFD_T3;
        end
        DFD_T3: begin
          next_state = trimmed_ready ? DFD_T4 : DFD_TW;
        end
        DFD_TW: begin
          // No cap on the wait; slow memory is trusted
          next_state = trimmed_ready ? DFD_T4 : DFD_TW;
        end
        DFD_T4: begin
          // Completion wins over FIFO or arbiter conditions
          if (!terminal_count_n) begin
            next_state = DFD_DONE;
          end else if (!synced_bus_grant || !queue_usable) begin
            next_state = DFD_DROP;
          end else begin
            next_state = DFD_T1;
          end
        end
        DFD_DROP: begin
          next_state = DFD_RELEASE;
        end
        DFD_RELEASE: begin
          // Extra cycle lets the arbiter hand the bus over
          next_state = DFD_WAIT_FIFO;
        end
        DFD_DONE: begin
          next_state = DFD_IDLE;
        end
        default: begin
          next_state = DFD_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= DFD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bus request held from send until the drop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      disk_bus_request <= 1'b0;
    end else begin
      disk_bus_request <= (next_state == DFD_SEND_REQ) || (next_state == DFD_WAIT_GRANT)
        || (next_state == DFD_TS) || in_bus_cycle(next_state);
    end
  end

  // Active from Ts until the cycle after a release drops the request; completion or error clears both at once
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      transfer_active <= 1'b0;
    end else begin
      transfer_active <= (next_state == DFD_TS) || in_bus_cycle(next_state)
        || (next_state == DFD_DROP);
    end
  end

  // Bus control pattern, decoded from the coming state
  always_comb begin
    next_bus_ctl.addr_phase_n = (next_state != DFD_T1);
    next_bus_ctl.mem_read_write_n = !((next_state == DFD_T2) || (next_state == DFD_T3)
      || (next_state == DFD_TW));
    next_bus_ctl.queue_prefetch_n = !((next_state == DFD_T4) || (next_state == DFD_T1));
    next_bus_ctl.status_line_gate = (next_state == DFD_TS) || (next_state == DFD_T1)
      || (next_state == DFD_T2);
    next_bus_ctl.status_lines = next_bus_ctl.status_line_gate ? mem_status(mem_to_disk)
      : `DFD_STAT_PASSIVE;
    next_bus_ctl.data_buffer_enable_n = !in_bus_cycle(next_state);
    next_bus_ctl.data_buffer_dir = !mem_to_disk;
  end

  // Bus control register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_ctl <= '{1'b1, 1'b1, 1'b1, 1'b0, `DFD_STAT_PASSIVE, 1'b1, 1'b0};
    end else begin
      bus_ctl <= next_bus_ctl;
    end
  end

  // Running flag: set by strobe, cleared only at completion or error
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sequencer_running <= 1'b0;
    end else if (next_state == DFD_DONE || illegal_input) begin
      sequencer_running <= 1'b0;
    end else if (!begin_strobe_n) begin
      sequencer_running <= 1'b1;
    end
  end

  // Interrupt held until the host starts again
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      disk_xfer_irq_n <= 1'b1;
    end else if (next_state == DFD_DONE || illegal_input) begin
      disk_xfer_irq_n <= 1'b0;
    end else if (!begin_strobe_n) begin
      disk_xfer_irq_n <= 1'b1;
    end
  end

  // Error is sticky; a new error beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      error_flag <= 1'b0;
    end else if (illegal_input) begin
      error_flag <= 1'b1;
    end else if (status_clear) begin
      error_flag <= 1'b0;
    end
  end

  addr_phase_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (bus_ctl.addr_phase_n == 1'b0) == (state == DFD_T1))
    else $error("address phase indicator out of step with T1");

  wait_insert_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_T3 && !synced_ready && !illegal_input) |=> (state == DFD_TW))
    else $error("low ready in T3 did not insert a wait state");

  wait_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_TW && !synced_ready && !illegal_input) |=> (state == DFD_TW) && !bus_ctl.mem_read_write_n)
    else $error("wait state ended while ready was low");

  start_strobe_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (begin_transfer_cmd && state == DFD_IDLE && !illegal_input) |=> !begin_strobe_n ##1 sequencer_running)
    else $error("start command did not set the running flag");

  grant_ts_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_WAIT_GRANT && synced_bus_grant && !illegal_input)
      |=> (state == DFD_TS) && transfer_active ##1 (state == DFD_T1))
    else $error("grant did not lead through Ts into T1");

  release_seq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_T4 && !synced_bus_grant && terminal_count_n && !illegal_input)
      |=> !disk_bus_request && transfer_active ##1 !transfer_active && !in_bus_cycle(state))
    else $error("bus release sequence wrong after grant loss");

  fifo_release_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_WAIT_FIFO && !queue_usable) |=> !disk_bus_request)
    else $error("bus requested while the FIFO was unusable");

  suspend_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_RELEASE) |-> sequencer_running)
    else $error("running flag dropped during suspension");

  done_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_DONE) |-> !disk_xfer_irq_n && !sequencer_running)
    else $error("completion without interrupt and cleared running flag");

  status_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !bus_ctl.status_line_gate |-> (bus_ctl.status_lines == `DFD_STAT_PASSIVE))
    else $error("status lines active while not gated");

  error_trap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    illegal_input |=> error_flag && (state == DFD_IDLE) && !disk_xfer_irq_n)
    else $error("illegal input did not trap to idle with error");

  // Pattern and handshake checks beyond the basic sequence
  run_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!begin_strobe_n && state == DFD_IDLE && !illegal_input) |=> (state == DFD_WAIT_FIFO) && sequencer_running)
    else $error("start strobe did not leave idle with running set");

  fifo_rerequest_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_WAIT_FIFO && queue_usable && !illegal_input) |=> (state == DFD_SEND_REQ) && disk_bus_request)
    else $error("usable FIFO did not raise the bus request");

  bus_active_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_bus_cycle(state) |-> transfer_active && disk_bus_request && !bus_ctl.data_buffer_enable_n)
    else $error("bus cycle without active, request or buffer enable");

  strobe_pattern_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!bus_ctl.queue_prefetch_n == (state == DFD_T4 || state == DFD_T1))
      && (!bus_ctl.mem_read_write_n == (state == DFD_T2 || state == DFD_T3 || state == DFD_TW)))
    else $error("strobe pattern out of step with the state");

  buffer_dir_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !bus_ctl.data_buffer_enable_n |-> (bus_ctl.data_buffer_dir == !$past(mem_to_disk)))
    else $error("buffer direction does not follow the transfer direction");

  mem_status_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_T1) |-> bus_ctl.status_line_gate && (bus_ctl.status_lines == mem_status($past(mem_to_disk))))
    else $error("status lines not showing a memory cycle in T1");

  fifo_drop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_T4 && !queue_usable && terminal_count_n && !illegal_input)
      |=> (state == DFD_DROP) && !disk_bus_request)
    else $error("unusable FIFO did not release the bus");

  term_done_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_T4 && !terminal_count_n && !illegal_input) |=> (state == DFD_DONE) && !disk_bus_request)
    else $error("terminal count in T4 did not complete the operation");

  release_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state == DFD_RELEASE) |-> !disk_bus_request && !transfer_active && !bus_ctl.status_line_gate)
    else $error("bus activity while released");

  ready_sync_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!$past(sys_rst) && !$past(sys_rst, 2)) |-> (synced_ready == $past(memory_ready_in, 2))
      && (synced_bus_grant == $past(disk_bus_grant, 2)))
    else $error("ready or grant not delayed by two flops");
endmodule // dfd_sequencer
`default_nettype wire

//--- testbench/dfd_far_side.sv
// Far-side model: bus arbiter and main memory facing the sequencer.
// Assumes the bench sets grant delay, wait length and preemption.
`timescale 1ns/1ns
`default_nettype none
module dfd_far_side
  import dfd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Sequencer side
  input wire logic disk_bus_request,
  input wire dfd_bus_ctl_t bus_ctl,
  output logic disk_bus_grant,
  output logic memory_ready_in,
  // Bench controls
  input wire logic [3:0] grant_delay,
  input wire logic [3:0] wait_len,
  input wire logic preempt
);
  logic [3:0] grant_cnt;
  logic [3:0] wait_cnt;

  // Arbiter: grants after a delay, withdraws for another master
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !disk_bus_request || preempt) begin
      grant_cnt <= 4'h0;
      disk_bus_grant <= 1'b0;
    end else if (grant_cnt >= grant_delay) begin
      disk_bus_grant <= 1'b1;
    end else begin
      grant_cnt <= grant_cnt + 4'h1;
    end
  end

  // Slow memory keeps ready low until its access has run long enough
  always_ff @(posedge ref_clk) begin
    if (sys_rst || bus_ctl.mem_read_write_n) begin
      wait_cnt <= 4'h0;
      memory_ready_in <= (wait_len == 4'h0);
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      memory_ready_in <= (wait_cnt + 4'h1 >= wait_len);
    end
  end
endmodule // dfd_far_side
`default_nettype wire

//--- testbench/disk_fifo_dma_bus_master_tb_top.sv
// Self-checking bench for the disk FIFO DMA sequencer.
// Assumes dfd_far_side plays arbiter and memory; the bench plays host and FIFO.
`timescale 1ns/1ns
`default_nettype none
`include "dfd_map.svh"
module disk_fifo_dma_bus_master_tb_top
  import dfd_pkg::*;
;
  logic ref_clk, sys_rst, begin_transfer_cmd, mem_to_disk, load_count, load_addr, status_clear;
  logic queue_full, queue_empty, memory_ready_in, disk_bus_grant, disk_bus_request, preempt;
  logic begin_strobe_n, sequencer_running, transfer_active, terminal_count_n, disk_xfer_irq_n, error_flag;
  logic [7:0] count_value;
  logic [23:0] addr_value, bus_address, op_addr;
  logic [3:0] grant_delay, wait_len;
  dfd_bus_ctl_t bus_ctl;
  int n_mismatch, comparisons, seed, n_t1, n_mrw, n_pf, n_drop, j;
  logic req_d, unusable_d, act_d, act_chk;

  dfd_sequencer u_dfd_sequencer (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .begin_transfer_cmd(begin_transfer_cmd), .mem_to_disk(mem_to_disk), .load_count(load_count),
    .count_value(count_value), .load_addr(load_addr), .addr_value(addr_value), .status_clear(status_clear),
    .queue_full(queue_full), .queue_empty(queue_empty), .memory_ready_in(memory_ready_in),
    .disk_bus_grant(disk_bus_grant), .disk_bus_request(disk_bus_request), .bus_ctl(bus_ctl),
    .bus_address(bus_address), .begin_strobe_n(begin_strobe_n), .sequencer_running(sequencer_running),
    .transfer_active(transfer_active), .terminal_count_n(terminal_count_n),
    .disk_xfer_irq_n(disk_xfer_irq_n), .error_flag(error_flag));

  dfd_far_side u_dfd_far_side (.ref_clk(ref_clk), .sys_rst(sys_rst), .disk_bus_request(disk_bus_request),
    .bus_ctl(bus_ctl), .disk_bus_grant(disk_bus_grant), .memory_ready_in(memory_ready_in),
    .grant_delay(grant_delay), .wait_len(wait_len), .preempt(preempt));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bus monitor; counts are cleared by each operation
  always @(posedge ref_clk) begin
    if (!sys_rst) begin
      if (bus_ctl.addr_phase_n === 1'b0) begin
        check_vec("T1 address", 24'(op_addr + 24'(2 * n_t1)), bus_address);
        check_bit("status gate", 1'b1, bus_ctl.status_line_gate);
        n_t1++;
        check_bit("active in T1", 1'b1, transfer_active);
        check_vec("status in T1", mem_to_disk ? `DFD_STAT_MEM_READ : `DFD_STAT_MEM_WRITE, bus_ctl.status_lines);
        check_bit("buffer enable", 1'b0, bus_ctl.data_buffer_enable_n);
        check_bit("buffer dir", !mem_to_disk, bus_ctl.data_buffer_dir);
      end
      if (transfer_active === 1'b0)
        check_vec("idle status", `DFD_STAT_PASSIVE, bus_ctl.status_lines);
      if (act_d === 1'b0 && transfer_active === 1'b1)
        check_bit("Ts no address", 1'b1, bus_ctl.addr_phase_n);
      if (act_chk)
        check_bit("active after drop", 1'b0, transfer_active);
      act_chk = 1'b0;
      if (req_d && disk_bus_request === 1'b0 && sequencer_running === 1'b1) begin
        n_drop++;
        check_bit("active at drop", 1'b1, transfer_active);
        act_chk = 1'b1;
      end
      if (req_d === 1'b0 && disk_bus_request === 1'b1)
        check_bit("queue usable", 1'b0, unusable_d);
      if (bus_ctl.mem_read_write_n === 1'b0) n_mrw++;
      if (bus_ctl.queue_prefetch_n === 1'b0) n_pf++;
    end
    req_d = disk_bus_request;
    act_d = transfer_active;
    unusable_d = mem_to_disk ? queue_full : queue_empty;
  end

  // One operation; mode 0 plain, 1 preempted, 2 queue stall, 3 illegal inputs
  task automatic run_op(input int n, input logic dir, input logic [3:0] k, input int mode);
    logic [23:0] a;
    int i;
    a = 24'($random(seed)) & 24'hfffffe;
    @(posedge ref_clk);
    #2;
    mem_to_disk = dir;
    wait_len = k;
    grant_delay = 4'($random(seed)) & 4'h7;
    load_count = 1'b1;
    count_value = 8'(-n);
    load_addr = 1'b1;
    addr_value = a;
    @(posedge ref_clk);
    #2;
    load_count = 1'b0;
    load_addr = 1'b0;
    begin_transfer_cmd = 1'b1;
    n_t1 = 0; n_mrw = 0; n_pf = 0; n_drop = 0;
    op_addr = a;
    @(posedge ref_clk);
    #2;
    begin_transfer_cmd = 1'b0;
    check_bit("start strobe", 1'b0, begin_strobe_n);
    @(posedge ref_clk);
    #2;
    check_bit("strobe end", 1'b1, begin_strobe_n);
    check_bit("running", 1'b1, sequencer_running);
    for (i = 0; i < 300 && transfer_active !== 1'b1; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    #2;
    if (mode == 1) begin
      preempt = 1'b1;
      repeat (12) @(posedge ref_clk);
      #2;
      preempt = 1'b0;
    end else if (mode == 2) begin
      if (dir) queue_full = 1'b1;
      else queue_empty = 1'b1;
      repeat (15) @(posedge ref_clk);
      #2;
      queue_full = 1'b0;
      queue_empty = 1'b0;
    end else if (mode == 3) begin
      queue_full = 1'b1;
      queue_empty = 1'b1;
      @(posedge ref_clk);
      #2;
      queue_full = 1'b0;
      queue_empty = 1'b0;
      @(posedge ref_clk);
      #2;
      check_vec("error state", 3'b100, {error_flag, disk_xfer_irq_n, sequencer_running});
      status_clear = 1'b1;
      @(posedge ref_clk);
      #2;
      status_clear = 1'b0;
      check_bit("error cleared", 1'b0, error_flag);
      $display("test illegal inputs done");
      return;
    end
    for (i = 0; i < 3000 && disk_xfer_irq_n !== 1'b0; i++) @(posedge ref_clk);
    #2;
    check_vec("end state", 3'b000, {disk_xfer_irq_n, sequencer_running, terminal_count_n});
    check_vec("words", n, n_t1);
    check_vec("address", 24'(a + 24'(2 * n)), bus_address);
    check_vec("data cycles", n * (2 + (k == 0 ? 0 : k + 1)), n_mrw);
    check_vec("prefetches", 2 * n, n_pf);
    if (mode != 0) check_bit("suspended", 1'b1, n_drop > 0);
    repeat (5) @(posedge ref_clk);
    #2;
    check_bit("no restart", 1'b0, disk_bus_request);
    $display("test words %0d waits %0d mode %0d done", n, k, mode);
  endtask

  // Main sequence: corner cases, then random operations
  initial begin
    seed = 32'h8263d070;
    {sys_rst, begin_transfer_cmd, mem_to_disk, load_count, load_addr, status_clear} = 6'h20;
    {queue_full, queue_empty, preempt, req_d, act_d, act_chk, unusable_d} = 7'h00;
    count_value = 8'h00; addr_value = 24'h000000; grant_delay = 4'h0; wait_len = 4'h0;
    n_mismatch = 0; comparisons = 0;
    repeat (6) @(posedge ref_clk);
    #2;
    sys_rst = 1'b0;
    check_vec("reset outputs", 7'h0d, {disk_bus_request, transfer_active, sequencer_running,
      disk_xfer_irq_n, begin_strobe_n, error_flag, terminal_count_n});
    check_vec("reset bus", 9'h1de, bus_ctl);
    check_vec("reset address", 24'h000000, bus_address);
    $display("test reset done");
    run_op(1, 1'b1, 4'h0, 0);
    run_op(3, 1'b0, 4'h1, 0);
    run_op(2, 1'b1, 4'h5, 0);
    run_op(4, 1'b0, 4'h0, 1);
    run_op(4, 1'b1, 4'h2, 2);
    run_op(3, 1'b0, 4'h0, 2);
    run_op(5, 1'b1, 4'h0, 3);
    for (j = 0; j < 12; j++)
      run_op(3 + {$random(seed)} % 4, 1'($random(seed)), 4'({$random(seed)} % 4), {$random(seed)} % 4);
    stop_test;
  end

  // Watchdog against a hung handshake
  initial begin
    #(40 * 60000);
    n_mismatch++;
    $display("watchdog expired");
    stop_test;
  end
endmodule // disk_fifo_dma_bus_master_tb_top
`default_nettype wire
